// [core/lhb_host_port.sv]
// lhb_host_port: parallel host port of a display controller with its
// display memory, one-stage bus holder and write fifo.
// assumes: all host pins are asynchronous to I_CLK; the pad ring merges
// O_HOST_DATA_BUS, O_HOST_DATA_OE and I_HOST_DATA_BUS into one wire.
`timescale 1ns/100ps
`include "lhb_params.svh"

module lhb_host_port (
  input  wire logic       I_CLK,
  input  wire logic       I_RESET_N,
  input  wire logic       I_RST_LEVEL,
  input  wire logic       I_CS_N,
  input  wire logic       I_REG_SELECT,
  input  wire logic       I_STROBE_A,
  input  wire logic       I_STROBE_B,
  input  wire logic [7:0] I_HOST_DATA_BUS,
  output logic      [7:0] O_HOST_DATA_BUS,
  output logic            O_HOST_DATA_OE,
  input  wire logic       I_ADC_NORMAL,
  input  wire logic       I_DISPLAY_OFF,
  output logic            O_CMD_VALID,
  output logic      [7:0] O_CMD_DATA,
  output logic            O_BUSY
);

  // =====================================================================
  // pin sampling
  lhb_pkg::lhb_pins_s pins_raw;
  lhb_pkg::lhb_pins_s p;

  assign pins_raw = '{rst_level: I_RST_LEVEL, cs_n: I_CS_N,
                      reg_select: I_REG_SELECT, strobe_a: I_STROBE_A,
                      strobe_b: I_STROBE_B, data: I_HOST_DATA_BUS};

  lhb_sync #(.W($bits(lhb_pkg::lhb_pins_s))) u_sync (
    .I_CLK     (I_CLK),
    .I_RESET_N (I_RESET_N),
    .i_async   (pins_raw),
    .o_sync    (p)
  );

  // =====================================================================
  // state
  lhb_pkg::lhb_acc_e state;
  lhb_pkg::lhb_op_e  op;
  logic              acc_sel;
  logic              style_80;
  logic [1:0]        warm;
  logic [7:0]        holder;
  logic              wr_pend;
  lhb_pkg::lhb_wr_s  wr_entry;
  logic              push_pend;
  lhb_pkg::lhb_wr_s  push_entry;
  logic              fetch_pend;
  logic [8:0]        fetch_idx;
  logic [1:0]        page;
  logic [6:0]        col;
  logic [7:0]        rd_byte;
  logic [4:0]        rst_cnt;
  logic [7:0]        dmem [4*`LHB_COLS];

  // =====================================================================
  // access classification
  wire strobe_on  = style_80 ? (!p.strobe_a || !p.strobe_b)
                             : p.strobe_a;
  wire strobe_rd  = style_80 ? !p.strobe_a : p.strobe_b;
  wire [1:0] cls  = {p.reg_select, strobe_rd};
  wire lhb_pkg::lhb_op_e next_op =
    (cls == 2'b11) ? lhb_pkg::LHB_OP_DATA_RD :
    (cls == 2'b10) ? lhb_pkg::LHB_OP_DATA_WR :
    (cls == 2'b01) ? lhb_pkg::LHB_OP_STATUS_RD :
                     lhb_pkg::LHB_OP_CMD_WR;

  // the syncs leave reset at zero, not at every strobe's idle level, so
  // no access opens until they carry real pin levels
  wire sync_ready = warm == 2'h0;
  wire acc_start  = (state == lhb_pkg::LHB_IDLE) && strobe_on
                    && sync_ready;
  wire acc_end    = (state == lhb_pkg::LHB_ACTIVE) && !strobe_on;
  wire end_dwr    = acc_end && acc_sel
                    && (op == lhb_pkg::LHB_OP_DATA_WR);
  wire end_drd    = acc_end && acc_sel
                    && (op == lhb_pkg::LHB_OP_DATA_RD);
  wire end_cmd    = acc_end && (op == lhb_pkg::LHB_OP_CMD_WR);
  wire is_reset   = p.data == `LHB_CMD_RESET;
  // standby drops every command except the reset one
  wire take_cmd   = end_cmd && (acc_sel || is_reset);
  wire cmd_page   = p.data[7:2] == `LHB_CMD_PAGE;
  wire cmd_col    = !p.data[7] && (p.data[6:0] <= `LHB_COL_LAST);
  wire cmd_fwd    = take_cmd && !is_reset && !cmd_page && !cmd_col;
  wire col_inc    = (end_dwr || end_drd) && (col != `LHB_COL_LAST);

  // =====================================================================
  // status byte and busy
  wire       rst_flag = rst_cnt != 5'h00;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  lhb_pkg::lhb_wr_s fifo_out;
  // busy lets the host hold off with no-operation cycles when it
  // cannot keep the cycle time
  wire       busy     = push_pend || fifo_out_valid
                        || fetch_pend || rst_flag;
  wire [7:0] status   = {busy, I_ADC_NORMAL, I_DISPLAY_OFF, rst_flag,
                         4'h0};

  function automatic logic [8:0] mem_idx(input logic [1:0] pg,
                                         input logic [6:0] cl);
    mem_idx = 9'(pg * `LHB_COLS) + {2'b00, cl};
  endfunction

  // =====================================================================
  // write path: holder -> fifo -> memory
  wire push_go  = push_pend && fifo_in_ready;
  // a fetch waits until every committed write has drained
  wire fetch_go = fetch_pend && !push_pend && !fifo_out_valid;
  wire drain    = fifo_out_valid && !fetch_go;

  lhb_fifo #(.W($bits(lhb_pkg::lhb_wr_s)), .DEPTH(`LHB_FIFO_DEPTH)) u_fifo (
    .I_CLK       (I_CLK),
    .I_RESET_N   (I_RESET_N),
    .i_in_valid  (push_pend),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (push_entry),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (!fetch_go),
    .o_out_data  (fifo_out)
  );

  always_ff @(posedge I_CLK) begin
    if (drain) begin
      dmem[mem_idx(fifo_out.page, fifo_out.col)] <= fifo_out.data;
    end
  end

  // =====================================================================
  // access state machine
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state   <= lhb_pkg::LHB_IDLE;
      op      <= lhb_pkg::LHB_OP_STATUS_RD;
      acc_sel <= 1'b0;
    end else begin
      case (state)
        lhb_pkg::LHB_IDLE: begin
          if (acc_start) begin
            state   <= lhb_pkg::LHB_ACTIVE;
            op      <= next_op;
            acc_sel <= !p.cs_n;
          end
        end
        default: begin
          if (!strobe_on) begin
            state <= lhb_pkg::LHB_IDLE;
          end
        end
      endcase
    end
  end

  // bus style strap: followed while the syncs fill after reset release,
  // then held; caught again on the reset command
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      style_80 <= `LHB_STYLE_68;
      warm     <= `LHB_SYNC_WARM;
    end else begin
      if (!sync_ready) begin
        warm <= warm - 2'h1;
      end
      if (!sync_ready || take_cmd && is_reset) begin
        style_80 <= p.rst_level;
      end
    end
  end

  // read byte is chosen when the strobe opens, so the answer is ready
  // three clocks plus the pad delay after the pin moves
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rd_byte <= 8'h00;
    end else if (acc_start && strobe_rd) begin
      rd_byte <= p.reg_select ? holder : status;
    end
  end

  // holder, pending write and fetch
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      holder     <= 8'h00;
      wr_pend    <= 1'b0;
      wr_entry   <= '0;
      push_pend  <= 1'b0;
      push_entry <= '0;
      fetch_pend <= 1'b0;
      fetch_idx  <= 9'h000;
    end else begin
      if (push_go) begin
        push_pend <= 1'b0;
      end
      // a finished fetch yields to an access ending at the same edge
      if (fetch_go) begin
        holder     <= dmem[fetch_idx];
        fetch_pend <= 1'b0;
      end
      // the previous byte is committed on the next data write or data read
      if (end_dwr || end_drd && wr_pend) begin
        push_pend  <= wr_pend || push_pend && !push_go;
        push_entry <= wr_pend ? wr_entry : push_entry;
      end
      if (end_dwr) begin
        holder   <= p.data;
        wr_pend  <= 1'b1;
        wr_entry <= '{page: page, col: col, data: p.data};
      end
      if (end_drd) begin
        wr_pend    <= 1'b0;
        fetch_pend <= 1'b1;
        fetch_idx  <= mem_idx(page, col);
      end
    end
  end

  // address registers and command output
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      page        <= `LHB_PAGE_RESET;
      col         <= 7'h00;
      O_CMD_VALID <= 1'b0;
      O_CMD_DATA  <= 8'h00;
      rst_cnt     <= 5'(`LHB_RST_FLAG_CYC);
    end else begin
      O_CMD_VALID <= cmd_fwd;
      if (cmd_fwd) begin
        O_CMD_DATA <= p.data;
      end
      if (rst_flag) begin
        rst_cnt <= rst_cnt - 5'h01;
      end
      if (take_cmd && is_reset) begin
        page    <= `LHB_PAGE_RESET;
        rst_cnt <= 5'(`LHB_RST_FLAG_CYC);
      end else if (take_cmd && cmd_page) begin
        page <= p.data[1:0];
      end else if (take_cmd && cmd_col) begin
        col <= p.data[6:0];
      end else if (col_inc) begin
        col <= col + 7'h01;
      end
    end
  end

  // =====================================================================
  // outputs
  assign O_HOST_DATA_BUS = rd_byte;
  assign O_HOST_DATA_OE  = (state == lhb_pkg::LHB_ACTIVE) && acc_sel
                           && (op == lhb_pkg::LHB_OP_DATA_RD
                               || op == lhb_pkg::LHB_OP_STATUS_RD);
  assign O_BUSY          = busy;

  // =====================================================================
  // checks
  sequence s_read_start;
    acc_start && strobe_rd;
  endsequence

  sequence s_data_write_end;
    end_dwr && !push_pend;
  endsequence

  a_oe_read_only: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    O_HOST_DATA_OE |-> acc_sel && state == lhb_pkg::LHB_ACTIVE)
    else $error("data lines driven outside a selected read");

  a_status_read: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    s_read_start and !p.reg_select |=> rd_byte == $past(status))
    else $error("status read did not return status byte");

  a_data_holder: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    s_read_start and p.reg_select |=> rd_byte == $past(holder))
    else $error("data read did not return holder content");

  a_write_holder: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    end_dwr |=> holder == $past(p.data) && wr_pend)
    else $error("written byte not held");

  a_commit_next: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    s_data_write_end and wr_pend |=>
      push_pend && push_entry == $past(wr_entry))
    else $error("held byte not committed on next write");

  a_cmd_pulse: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    cmd_fwd |=> O_CMD_VALID && O_CMD_DATA == $past(p.data)
      ##1 !O_CMD_VALID || $past(cmd_fwd))
    else $error("command not forwarded as one pulse");

  a_standby_ignore: assert property (@(posedge I_CLK)
    disable iff (!I_RESET_N)
    acc_end && !acc_sel |=> $stable(holder) && !O_CMD_VALID
      && !$rose(wr_pend))
    else $error("deselected access changed the port");

  a_fetch_bound: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    $rose(fetch_pend) |-> ##[1:40] !fetch_pend)
    else $error("memory fetch took too long");

  a_style_start: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    state == lhb_pkg::LHB_IDLE && style_80 && !p.strobe_a
      |=> state == lhb_pkg::LHB_ACTIVE)
    else $error("80-style read strobe not recognised");

endmodule

// [core/lhb_params.svh]
// lhb_params.svh: offsets, reset values and timing counts of the host port
// assumes: included by its bare name by the host port and the bench
`ifndef LHB_PARAMS_SVH
`define LHB_PARAMS_SVH

// =====================================================================
// display memory geometry
`define LHB_COLS        80
`define LHB_COL_LAST    7'h4F
`define LHB_PAGE_RESET  2'h3

// =====================================================================
// command codes seen by the port itself, and the bus style loaded at reset
`define LHB_CMD_RESET   8'hE2
`define LHB_CMD_PAGE    6'h2E
`define LHB_STYLE_68    1'b0

// =====================================================================
// status byte layout
`define LHB_ST_BUSY     7
`define LHB_ST_ADC      6
`define LHB_ST_OFF      5
`define LHB_ST_RESET    4

// =====================================================================
// timing
`define LHB_CLK_NS      50
`define LHB_RST_FLAG_NS 1000
`define LHB_RST_FLAG_CYC \
  ((`LHB_RST_FLAG_NS + `LHB_CLK_NS - 1) / `LHB_CLK_NS)
`define LHB_FIFO_DEPTH  32
`define LHB_SYNC_WARM   2'h3

`endif

// [core/lhb_pkg.sv]
// lhb_pkg: types shared by the host port and its helpers
// assumes: lhb_params.svh holds all numeric constants
package lhb_pkg;

  typedef enum logic [1:0] {
    LHB_OP_DATA_RD,
    LHB_OP_DATA_WR,
    LHB_OP_STATUS_RD,
    LHB_OP_CMD_WR
  } lhb_op_e;

  typedef enum logic {
    LHB_IDLE,
    LHB_ACTIVE
  } lhb_acc_e;

  // one pending display write: where and what
  typedef struct packed {
    logic [1:0] page;
    logic [6:0] col;
    logic [7:0] data;
  } lhb_wr_s;

  // host pins as sampled; strobe_a is E or read, strobe_b is r/w or write
  typedef struct packed {
    logic       rst_level;
    logic       cs_n;
    logic       reg_select;
    logic       strobe_a;
    logic       strobe_b;
    logic [7:0] data;
  } lhb_pins_s;

endpackage

// [core/lhb_sync.sv]
// lhb_sync: two-flop synchroniser for a bundle of pin levels
// assumes: inputs are asynchronous levels; output lags by two clocks
`timescale 1ns/100ps

module lhb_sync #(
  parameter int W = 1
) (
  input  wire logic         I_CLK,
  input  wire logic         I_RESET_N,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // =====================================================================
  // the first stage feeds only the second
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// [core/lhb_fifo.sv]
// lhb_fifo: small synchronous fifo with valid/ready on both sides
// assumes: one clock; DEPTH is a power of two
`timescale 1ns/100ps

module lhb_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 32
) (
  input  wire logic         I_CLK,
  input  wire logic         I_RESET_N,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  wire          push = i_in_valid && o_in_ready;
  wire          pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_ptr != rd_ptr;
  assign o_out_data  = mem[rd_ptr[AW-1:0]];

  // =====================================================================
  // pointers carry one wrap bit so full and empty are distinct
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end

endmodule

// [sim/lhb_host_model.sv]
// lhb_host_model: microprocessor on the far side of the host port,
// speaking either the enable plus r/w bus or the split strobe bus.
// assumes: called at a fixed 5 ns after a rising edge of i_clk.
`timescale 1ns/100ps

module lhb_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_bus,
  output logic            o_cs_n,
  output logic            o_reg_select,
  output logic            o_strobe_a,
  output logic            o_strobe_b,
  output logic            o_oe,
  output logic      [7:0] o_data
);
  logic style;

  // =====================================================================
  // idle levels: enable low and r/w high, or both strobes high
  task automatic idle(input logic s);
    style = s;
    o_cs_n = 1'b1;
    o_reg_select = 1'b0;
    o_oe = 1'b0;
    o_data = 8'h00;
    o_strobe_a = s;
    o_strobe_b = 1'b1;
  endtask

  // =====================================================================
  // one bus cycle; fast keeps only the minimum strobe spacing
  task automatic access(input logic cs_n, input logic rs, input logic rd,
                        input logic [7:0] wd, input logic fast,
                        output logic [7:0] rv);
    int act;
    int gap;
    act = fast ? 4 : 6;
    gap = fast ? 2 : 6;  // idle cycles act as a wait
    o_cs_n = cs_n;
    o_reg_select = rs;
    o_data = wd;
    o_oe = !rd;
    if (!style) o_strobe_b = rd;
    @(posedge i_clk);
    #5;
    if (!style) o_strobe_a = 1'b1;
    else if (rd) o_strobe_a = 1'b0;
    else o_strobe_b = 1'b0;
    repeat (act) @(posedge i_clk);
    #5;
    rv = i_bus;
    o_strobe_a = style;
    if (style) o_strobe_b = 1'b1;
    // data and select held one cycle past the strobe, then let go
    @(posedge i_clk);
    #5;
    idle(style);
    repeat (gap) @(posedge i_clk);
    #5;
  endtask
endmodule

// [sim/tb_top.sv]
// tb_top: self-checking bench for the host port in both bus styles
// assumes: lhb_host_model plays the host; the bus wire is resolved here
`timescale 1ns/100ps
`include "lhb_params.svh"

module tb_top;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       rst_level = 1'b0;
  logic       adc = 1'b0;
  logic       off = 1'b0;
  logic       cs_n, rs, sa, sb, h_oe, d_oe, cmd_v, busy;
  logic [7:0] h_data, d_data, cmd_data, bus, rv;
  logic [7:0] idle_pat = 8'hA5;
  logic [7:0] mem [0:3][0:79];
  logic [7:0] holder;
  logic [1:0] pg;
  logic [6:0] col;
  logic [7:0] cmds [6] = '{8'hAE, 8'hAF, 8'hA0, 8'hA1, 8'hC0, 8'hEE};
  int         error_cnt = 0;
  int         checks = 0;
  int         cmd_cnt = 0;
  int         oe_cyc = 0;
  int         clash = 0;

  always #25 clk = ~clk;

  // released wire shows a pattern that changes every cycle
  assign bus = (d_oe === 1'b1) ? d_data : (h_oe ? h_data : idle_pat);

  lhb_host_port dut (.I_CLK(clk), .I_RESET_N(rst_n),
    .I_RST_LEVEL(rst_level), .I_CS_N(cs_n), .I_REG_SELECT(rs),
    .I_STROBE_A(sa), .I_STROBE_B(sb), .I_HOST_DATA_BUS(bus),
    .O_HOST_DATA_BUS(d_data), .O_HOST_DATA_OE(d_oe),
    .I_ADC_NORMAL(adc), .I_DISPLAY_OFF(off), .O_CMD_VALID(cmd_v),
    .O_CMD_DATA(cmd_data), .O_BUSY(busy));

  lhb_host_model host (.i_clk(clk), .i_bus(bus), .o_cs_n(cs_n),
    .o_reg_select(rs), .o_strobe_a(sa), .o_strobe_b(sb), .o_oe(h_oe),
    .o_data(h_data));

  // =====================================================================
  // monitors
  always @(posedge clk) begin
    idle_pat <= ~idle_pat;
    if (cmd_v === 1'b1) cmd_cnt <= cmd_cnt + 1;
    if (d_oe === 1'b1) oe_cyc <= oe_cyc + 1;
    if (d_oe === 1'b1 && h_oe) clash <= clash + 1;
  end

  // =====================================================================
  // comparison, verdict and expectations
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [6:0] next_col(input logic [6:0] c);
    return (c == `LHB_COL_LAST) ? c : c + 7'h01;
  endfunction

  function automatic logic [7:0] status_exp(input logic rflag);
    return {rflag, adc, off, rflag, 4'h0};
  endfunction

  // =====================================================================
  // host operations that keep the expected memory, holder and column
  task automatic cmd(input logic [7:0] c, input logic sel);
    host.access(~sel, 1'b0, 1'b0, c, 1'b0, rv);
    if (sel || c == `LHB_CMD_RESET) begin
      if (c[7:2] == `LHB_CMD_PAGE) pg = c[1:0];
      else if (c <= {1'b0, `LHB_COL_LAST}) col = c[6:0];
      else if (c == `LHB_CMD_RESET) pg = `LHB_PAGE_RESET;
    end
  endtask

  task automatic wr(input logic [7:0] d, input logic sel);
    host.access(~sel, 1'b1, 1'b0, d, 1'($urandom % 2), rv);
    if (sel) begin
      mem[pg][col] = d;
      holder = d;
      col = next_col(col);
    end
  endtask

  task automatic rd(input logic sel);
    host.access(~sel, 1'b1, 1'b1, 8'h00, 1'($urandom % 2), rv);
    if (sel) begin
      chk(rv, holder);
      holder = mem[pg][col];
      col = next_col(col);
    end
  endtask

  task automatic st(input logic [7:0] exp);
    host.access(1'b0, 1'b0, 1'b1, 8'h00, 1'b0, rv);
    chk(rv, exp);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      @(posedge clk);
      #5;
      n++;
    end
    chk({7'h00, busy}, 8'h00);
    if (busy !== 1'b0) results();
  endtask

  // =====================================================================
  // main sequence: one pass per bus style, reset again in mid-run
  initial begin
    int n0;
    int n1;
    logic [6:0] c0;
    void'($urandom(32'hE5AE));
    for (int s = 0; s < 2; s++) begin
      rst_n = 1'b0;
      rst_level = s[0];
      host.idle(s[0]);
      repeat (12) @(posedge clk);
      #5;
      rst_n = 1'b1;
      adc = 1'($urandom);
      off = 1'($urandom);
      wait_ready();
      st(status_exp(1'b0));
      foreach (cmds[i]) begin
        n0 = cmd_cnt;
        cmd(cmds[i], 1'b1);
        chk(8'(cmd_cnt - n0), 8'h01);
        chk(cmd_data, cmds[i]);
      end
      cmd(8'hB8 | 8'($urandom % 4), 1'b1);
      c0 = 7'($urandom % 64);
      cmd({1'b0, c0}, 1'b1);
      repeat (6) wr(8'($urandom), 1'b1);
      cmd({1'b0, c0}, 1'b1);
      // deselected traffic must leave memory, holder and column alone
      n0 = oe_cyc;
      n1 = cmd_cnt;
      wr(8'h3C, 1'b0);
      cmd(8'h00, 1'b0);
      rd(1'b0);
      cmd(8'hAE, 1'b0);
      chk(8'(oe_cyc - n0), 8'h00);
      chk(8'(cmd_cnt - n1), 8'h00);
      repeat (7) rd(1'b1);  // first read is the dummy
      // column stops at its last value
      cmd(8'h4E, 1'b1);
      repeat (3) wr(8'($urandom), 1'b1);
      cmd(8'h4E, 1'b1);
      repeat (4) rd(1'b1);
      cmd(`LHB_CMD_RESET, 1'b0);
      st(status_exp(1'b1));
    end
    chk(8'(clash), 8'h00);
    results();
  end

  // watchdog against a hung run
  initial begin
    #(50 * 90000);
    chk(8'h01, 8'h00);
    results();
  end
endmodule
